// File: design/agptt_pkg.sv
// Shared constants and types of the AGP tenure timer block
package agptt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] AGPTT_MT_IDX      = 12'h0BC;
    localparam logic [11:0] AGPTT_LP_IDX      = 12'h0BD;
    localparam logic [11:0] AGPTT_STAT_IDX    = 12'h0C0;
    localparam logic [11:0] AGPTT_MT_ADDR     = {AGPTT_MT_IDX[9:0], 2'b00};
    localparam logic [11:0] AGPTT_LP_ADDR     = {AGPTT_LP_IDX[9:0], 2'b00};
    localparam logic [11:0] AGPTT_STAT_ADDR   = {AGPTT_STAT_IDX[9:0], 2'b00};
    // Slice count field and reset values
    localparam int          AGPTT_CNT_MSB     = 7;
    localparam int          AGPTT_CNT_LSB     = 3;
    localparam logic [7:0]  AGPTT_MT_RESET    = 8'h10;
    localparam logic [7:0]  AGPTT_LP_RESET    = 8'h10;
    // Status word layout
    localparam int          AGPTT_ST_OWN_LSB  = 0;
    localparam int          AGPTT_ST_TYPE_BIT = 3;
    localparam int          AGPTT_ST_MT_LSB   = 8;
    localparam int          AGPTT_ST_LP_LSB   = 16;

    // Bus owner, Gray coded along idle-ext-host-lp-hp
    typedef enum logic [2:0] {
        AGPTT_IDLE = 3'b000,
        AGPTT_EXT  = 3'b001,
        AGPTT_HOST = 3'b011,
        AGPTT_LP   = 3'b010,
        AGPTT_HP   = 3'b110
    } agptt_owner_t;

    typedef struct packed {
        logic ext;
        logic host;
        logic lp;
        logic lp_write;
        logic hp;
    } agptt_req_t;

    typedef struct packed {
        logic ext;
        logic host;
        logic lp;
        logic hp;
    } agptt_gnt_t;
endpackage

// File: design/agptt_timer.sv
// Down-counting tenure timer, loaded at the start of a tenure
`timescale 1ns/1ps
module agptt_timer #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic      [W-1:0] remaining,
    output logic              expired
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign cnt_next  = load ? value : ((cnt_reg != '0) ? W'(cnt_reg - 1'b1) : '0);
    assign remaining = cnt_reg;
    assign expired   = (cnt_reg == '0);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule

// File: design/agptt_regs.sv
// Avalon-MM slave holding the two tenure timer registers and status
`timescale 1ns/1ps
module agptt_regs (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [31:0] status_word,
    output logic      [4:0]  mt_count,
    output logic      [4:0]  lp_count
);
    logic [4:0]  mt_reg;
    logic [4:0]  lp_reg;
    logic [31:0] rdata_next;
    logic        wait_next;
    logic        do_write;
    logic        hit_mt;
    logic        hit_lp;

    // One wait cycle: waitrequest drops in the cycle after the request
    assign wait_next  = ~((avs_read | avs_write) & avs_waitrequest);
    assign do_write   = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign hit_mt     = (avs_address == agptt_pkg::AGPTT_MT_ADDR);
    assign hit_lp     = (avs_address == agptt_pkg::AGPTT_LP_ADDR);
    // Reserved low bits and unmapped words read as zero
    assign rdata_next = hit_mt ? {24'h000000, mt_reg, 3'h0} :
                        hit_lp ? {24'h000000, lp_reg, 3'h0} :
                        (avs_address == agptt_pkg::AGPTT_STAT_ADDR) ? status_word : 32'h00000000;
    assign mt_count   = mt_reg;
    assign lp_count   = lp_reg;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            mt_reg          <= agptt_pkg::AGPTT_MT_RESET[agptt_pkg::AGPTT_CNT_MSB:agptt_pkg::AGPTT_CNT_LSB];
            lp_reg          <= agptt_pkg::AGPTT_LP_RESET[agptt_pkg::AGPTT_CNT_MSB:agptt_pkg::AGPTT_CNT_LSB];
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end
        else
        begin
            avs_waitrequest <= wait_next;
            avs_readdata    <= rdata_next;
            if (do_write && hit_mt)
                mt_reg <= avs_writedata[agptt_pkg::AGPTT_CNT_MSB:agptt_pkg::AGPTT_CNT_LSB];
            if (do_write && hit_lp)
                lp_reg <= avs_writedata[agptt_pkg::AGPTT_CNT_MSB:agptt_pkg::AGPTT_CNT_LSB];
        end
    end

    property p_mt_write;
        @(posedge clock) disable iff (sys_rst)
        (avs_write && !avs_waitrequest && hit_mt && avs_byteenable[0])
            |=> (mt_count == $past(avs_writedata[7:3]));
    endproperty
    a_mt_write: assert property (p_mt_write) else $error("slice count write lost");

    property p_lp_read;
        @(posedge clock) disable iff (sys_rst)
        (avs_read && avs_waitrequest && hit_lp)
            |=> (avs_readdata == {24'h000000, lp_count, 3'h0}) && !avs_waitrequest;
    endproperty
    a_lp_read: assert property (p_lp_read) else $error("low priority readback wrong");
endmodule

// File: design/agptt_arbiter.sv
// AGP/PCI bus arbiter with multi-transaction and low-priority tenure timers
`timescale 1ns/1ps
module agptt_arbiter (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic [11:0]          avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire agptt_pkg::agptt_req_t req,
    output agptt_pkg::agptt_gnt_t      gnt,
    output logic                      lp_write_type
);
    agptt_pkg::agptt_owner_t owner_reg;
    agptt_pkg::agptt_owner_t owner_next;
    agptt_pkg::agptt_gnt_t   gnt_reg;
    agptt_pkg::agptt_gnt_t   gnt_next;
    logic                    type_reg;
    logic                    type_next;
    logic [4:0]              mt_count;
    logic [4:0]              lp_count;
    logic [7:0]              mt_value;
    logic [7:0]              lp_value;
    logic [7:0]              mt_rem;
    logic [7:0]              lp_rem;
    logic                    mt_expired;
    logic                    lp_expired;
    logic                    mt_disabled;
    logic                    lp_disabled;
    logic                    mt_yield;
    logic                    lp_yield;
    logic                    mt_load;
    logic                    lp_load;
    logic                    lp_same;
    logic                    other_ml;
    logic [31:0]             status_word;
    agptt_pkg::agptt_owner_t idle_pick;

    agptt_regs u_regs (
        .clock           (clock),
        .sys_rst         (sys_rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .status_word     (status_word),
        .mt_count        (mt_count),
        .lp_count        (lp_count)
    );

    // byte value is the clock count
    assign mt_value = {mt_count, 3'h0};
    // byte value is the clock count
    assign lp_value = {lp_count, 3'h0};

    assign mt_disabled = (mt_count == 5'h00);
    assign mt_yield    = ~mt_disabled & mt_expired;
    assign lp_disabled = (lp_count == 5'h00);
    assign lp_yield    = lp_disabled | lp_expired;
    assign lp_same     = (req.lp_write == type_reg);
    assign other_ml    = req.ext | req.host;

    // High priority wins from idle, then low priority; master before host bridge
    assign idle_pick = req.hp   ? agptt_pkg::AGPTT_HP   :
                       req.lp   ? agptt_pkg::AGPTT_LP   :
                       req.ext  ? agptt_pkg::AGPTT_EXT  :
                       req.host ? agptt_pkg::AGPTT_HOST : agptt_pkg::AGPTT_IDLE;

    always_comb
    begin
        owner_next = owner_reg;
        if (req.hp)
            owner_next = agptt_pkg::AGPTT_HP;
        else
        begin
            case (owner_reg)
                agptt_pkg::AGPTT_EXT:
                begin
                    if (!req.ext)
                        owner_next = req.host ? agptt_pkg::AGPTT_HOST : idle_pick;
                    else if (mt_yield && req.host)
                        owner_next = agptt_pkg::AGPTT_HOST;
                    else if (mt_yield && req.lp)
                        owner_next = agptt_pkg::AGPTT_LP;
                end
                agptt_pkg::AGPTT_HOST:
                begin
                    if (!req.host)
                        owner_next = req.ext ? agptt_pkg::AGPTT_EXT : idle_pick;
                    else if (mt_yield && req.ext)
                        owner_next = agptt_pkg::AGPTT_EXT;
                    else if (mt_yield && req.lp)
                        owner_next = agptt_pkg::AGPTT_LP;
                end
                agptt_pkg::AGPTT_LP:
                begin
                    // yield only to a pending request
                    if (!req.lp)
                        owner_next = idle_pick;
                    else if (lp_yield && other_ml)
                        owner_next = req.ext ? agptt_pkg::AGPTT_EXT : agptt_pkg::AGPTT_HOST;
                end
                agptt_pkg::AGPTT_IDLE,
                agptt_pkg::AGPTT_HP:
                    owner_next = idle_pick;
                default:
                    owner_next = agptt_pkg::AGPTT_IDLE;
            endcase
        end
    end

    assign mt_load = (owner_next != owner_reg) &&
                     ((owner_next == agptt_pkg::AGPTT_EXT) || (owner_next == agptt_pkg::AGPTT_HOST));
    assign lp_load = (owner_next == agptt_pkg::AGPTT_LP) &&
                     ((owner_reg != agptt_pkg::AGPTT_LP) || !lp_same);
    assign type_next = lp_load ? req.lp_write : type_reg;

    assign gnt_next.ext  = (owner_next == agptt_pkg::AGPTT_EXT);
    assign gnt_next.host = (owner_next == agptt_pkg::AGPTT_HOST);
    assign gnt_next.lp   = (owner_next == agptt_pkg::AGPTT_LP);
    assign gnt_next.hp   = (owner_next == agptt_pkg::AGPTT_HP);

    agptt_timer #(.W(8)) u_mt_timer (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .load      (mt_load),
        .value     (mt_value),
        .remaining (mt_rem),
        .expired   (mt_expired)
    );

    agptt_timer #(.W(8)) u_lp_timer (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .load      (lp_load),
        .value     (lp_value),
        .remaining (lp_rem),
        .expired   (lp_expired)
    );

    assign status_word = {8'h00, lp_rem, mt_rem, 4'h0, type_reg, owner_reg};

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            owner_reg <= agptt_pkg::AGPTT_IDLE;
            gnt_reg   <= '0;
            type_reg  <= 1'b0;
        end
        else
        begin
            owner_reg <= owner_next;
            gnt_reg   <= gnt_next;
            type_reg  <= type_next;
        end
    end

    assign gnt           = gnt_reg;
    assign lp_write_type = type_reg;

    default clocking cb_arb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_ext_hold;
        (owner_reg == agptt_pkg::AGPTT_EXT) && req.ext && !req.hp && !mt_yield;
    endsequence

    sequence s_lp_enter;
        (owner_next == agptt_pkg::AGPTT_LP) && (owner_reg != agptt_pkg::AGPTT_LP) && !lp_disabled;
    endsequence

    sequence s_lp_stay;
        req.lp && lp_same && !req.hp && !other_ml;
    endsequence

    property p_ext_tenure;
        s_ext_hold |=> (owner_reg == agptt_pkg::AGPTT_EXT) && gnt.ext;
    endproperty
    a_ext_tenure: assert property (p_ext_tenure) else $error("master lost bus inside slice");

    property p_mt_off;
        ((owner_reg == agptt_pkg::AGPTT_EXT) && mt_disabled && req.ext && req.host && !req.hp)
            |=> (owner_reg == agptt_pkg::AGPTT_EXT);
    endproperty
    a_mt_off: assert property (p_mt_off) else $error("disabled slice still handed over");

    property p_host_slice;
        ((owner_reg == agptt_pkg::AGPTT_HOST) && req.host && req.ext && !req.hp && mt_yield)
            |=> (owner_reg == agptt_pkg::AGPTT_EXT) && gnt.ext;
    endproperty
    a_host_slice: assert property (p_host_slice) else $error("host kept bus past slice");

    property p_lp_min;
        s_lp_enter ##1 (req.lp && lp_same && !req.hp)
            |=> (owner_reg == agptt_pkg::AGPTT_LP) && (lp_rem == 8'($past(lp_value, 2) - 8'h01));
    endproperty
    a_lp_min: assert property (p_lp_min) else $error("low priority tenure cut short");

    property p_lp_span;
        ((owner_reg == agptt_pkg::AGPTT_LP) && req.lp && lp_same && !req.hp && (lp_rem != 8'h00))
            |=> (lp_rem == 8'($past(lp_rem) - 8'h01));
    endproperty
    a_lp_span: assert property (p_lp_span) else $error("low priority tenure restarted");

    property p_lp_keep;
        ((owner_reg == agptt_pkg::AGPTT_LP) && lp_yield) ##0 s_lp_stay
            |=> (owner_reg == agptt_pkg::AGPTT_LP);
    endproperty
    a_lp_keep: assert property (p_lp_keep) else $error("bus left idle low priority owner");

    property p_hp_direct;
        req.hp |=> (owner_reg == agptt_pkg::AGPTT_HP) && gnt.hp && !gnt.lp;
    endproperty
    a_hp_direct: assert property (p_hp_direct) else $error("high priority request held off");

    property p_lp_off;
        ((owner_reg == agptt_pkg::AGPTT_LP) && lp_disabled && req.lp && req.ext && !req.hp)
            |=> (owner_reg == agptt_pkg::AGPTT_EXT);
    endproperty
    a_lp_off: assert property (p_lp_off) else $error("disabled minimum tenure still held");

    property p_mt_load;
        mt_load |=> (mt_rem == $past(mt_value));
    endproperty
    a_mt_load: assert property (p_mt_load) else $error("slice timer not loaded");

    // Grant outputs are registered copies of the owner, so they must agree every cycle
    property p_gnt_owner;
        $onehot0(gnt) &&
            (gnt.ext == (owner_reg == agptt_pkg::AGPTT_EXT)) && (gnt.hp == (owner_reg == agptt_pkg::AGPTT_HP)) &&
            (gnt.host == (owner_reg == agptt_pkg::AGPTT_HOST)) && (gnt.lp == (owner_reg == agptt_pkg::AGPTT_LP));
    endproperty
    a_gnt_owner: assert property (p_gnt_owner) else $error("grant does not match owner");

    property p_host_hold;
        ((owner_reg == agptt_pkg::AGPTT_HOST) && req.host && !req.hp && !mt_yield)
            |=> (owner_reg == agptt_pkg::AGPTT_HOST) && gnt.host;
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("host bridge lost bus inside slice");

    property p_mt_count;
        ((owner_reg == agptt_pkg::AGPTT_EXT) && (owner_next == agptt_pkg::AGPTT_EXT) && (mt_rem != 8'h00))
            |=> (mt_rem == 8'($past(mt_rem) - 8'h01));
    endproperty
    a_mt_count: assert property (p_mt_count) else $error("slice timer missed a clock");

    property p_lp_hold;
        ((owner_reg == agptt_pkg::AGPTT_LP) && req.lp && !req.hp && !lp_disabled && !lp_expired)
            |=> (owner_reg == agptt_pkg::AGPTT_LP) && gnt.lp;
    endproperty
    a_lp_hold: assert property (p_lp_hold) else $error("low priority lost bus inside tenure");

    // A type change must reload the timer, otherwise mixed traffic would ride one tenure
    property p_lp_retype;
        ((owner_reg == agptt_pkg::AGPTT_LP) && req.lp && !lp_same && !req.hp && !(lp_yield && other_ml))
            |=> (lp_rem == $past(lp_value)) && (lp_write_type == $past(req.lp_write));
    endproperty
    a_lp_retype: assert property (p_lp_retype) else $error("type change kept old tenure");

    property p_lp_type_keep;
        ((owner_reg == agptt_pkg::AGPTT_LP) && req.lp && lp_same && !req.hp)
            |=> (lp_write_type == $past(lp_write_type));
    endproperty
    a_lp_type_keep: assert property (p_lp_type_keep) else $error("transfer type changed inside tenure");

    property p_lp_load;
        lp_load |=> (lp_rem == $past(lp_value)) && gnt.lp;
    endproperty
    a_lp_load: assert property (p_lp_load) else $error("low priority timer not loaded");

    property p_hp_release;
        ((owner_reg == agptt_pkg::AGPTT_HP) && !req.hp && req.lp)
            |=> (owner_reg == agptt_pkg::AGPTT_LP) && gnt.lp;
    endproperty
    a_hp_release: assert property (p_hp_release) else $error("bus not back to low priority");

    // Nobody asking means nobody keeps a grant, so a vanished master cannot hold the bus
    property p_release;
        (!req.ext && !req.host && !req.lp && !req.hp) |=> (gnt == 4'h0);
    endproperty
    a_release: assert property (p_release) else $error("grant held with no request");
endmodule

// File: tb/agptt_ext_master.sv
// Behavioural external AGP/PCI master that asks for the bus
`timescale 1ns/1ps
module agptt_ext_master (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       start,
    input  wire logic [7:0] beats,
    input  wire logic [1:0] lag,
    input  wire logic       granted,
    output logic            want
);
    int left;
    int hold;

    // Keeps asking after losing the bus, as a real master retries its burst
    always_ff @(posedge clock)
    begin
        if (sys_rst || start)
        begin
            left <= sys_rst ? 0 : int'(beats);
            hold <= sys_rst ? 0 : int'(lag);
            want <= 1'b0;
        end
        else if (hold > 0)
            hold <= hold - 1;
        else
        begin
            if (granted && want)
                left <= left - 1;
            want <= (left > ((granted && want) ? 1 : 0));
        end
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the AGP tenure arbiter
`timescale 1ns/1ps
module testbench;
    logic                  clock          = 1'b0;
    logic                  sys_rst        = 1'b1;
    logic [11:0]           avs_address    = 12'h000;
    logic                  avs_read       = 1'b0;
    logic                  avs_write      = 1'b0;
    logic [31:0]           avs_writedata  = 32'h00000000;
    logic [3:0]            avs_byteenable = 4'hF;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    agptt_pkg::agptt_req_t req;
    agptt_pkg::agptt_gnt_t gnt;
    logic                  lp_write_type;
    logic                  host_rq        = 1'b0;
    logic                  lp_rq          = 1'b0;
    logic                  lp_wr          = 1'b0;
    logic                  hp_rq          = 1'b0;
    logic                  ext_start      = 1'b0;
    logic [7:0]            ext_beats      = 8'h00;
    logic [1:0]            ext_lag        = 2'h0;
    logic                  ext_want;
    int                    failures       = 0;
    int                    tests_run      = 0;
    int                    cycles         = 0;
    int                    model_mt       = 16;
    int                    model_lp       = 16;
    int                    n;
    int                    lag;
    logic [31:0]           q;
    logic [7:0]            v;

    assign req = {ext_want, host_rq, lp_rq, lp_wr, hp_rq};

    agptt_arbiter agptt_arbiter_inst (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .req(req), .gnt(gnt), .lp_write_type(lp_write_type));
    agptt_ext_master agptt_ext_master_inst (.clock(clock), .sys_rst(sys_rst), .start(ext_start),
        .beats(ext_beats), .lag(ext_lag), .granted(gnt.ext), .want(ext_want));

    always #12.5 clock = ~clock;

    task automatic print_verdict();
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Runs are a few hundred cycles; anything near this is a hang
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer; the model tracks what a write should leave behind
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0)
            @(posedge clock);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (wr && be[0] && a == agptt_pkg::AGPTT_MT_ADDR)
            model_mt = int'(d & 8'hF8);
        if (wr && be[0] && a == agptt_pkg::AGPTT_LP_ADDR)
            model_lp = int'(d & 8'hF8);
    endtask

    task automatic ext_go(input logic [7:0] b, input int lg);
        @(posedge clock);
        ext_beats <= b;
        ext_lag <= 2'(lg);
        ext_start <= 1'b1;
        @(posedge clock);
        ext_start <= 1'b0;
    endtask

    task automatic wait_on(input int b);
        while (gnt[b] !== 1'b1)
            @(posedge clock);
    endtask

    task automatic count_on(input int b, output int c);
        c = 0;
        while (gnt[b] === 1'b1)
        begin
            c++;
            @(posedge clock);
        end
    endtask

    initial
    begin
        v = 8'($urandom(21450));
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b0, agptt_pkg::AGPTT_MT_ADDR, 8'h00, 4'hF);
        check(q, 32'(model_mt));
        bus(1'b0, agptt_pkg::AGPTT_LP_ADDR, 8'h00, 4'hF);
        check(q, 32'(model_lp));
        bus(1'b1, agptt_pkg::AGPTT_LP_ADDR, 8'($urandom), 4'hE);
        bus(1'b0, agptt_pkg::AGPTT_LP_ADDR, 8'h00, 4'hF);
        check(q, 32'(model_lp));
        bus(1'b1, 12'h004, 8'hFF, 4'hF);
        bus(1'b0, 12'h004, 8'h00, 4'hF);
        check(q, 32'h00000000);
        // Slice handover ext to host and back, documented example first
        for (int k = 0; k < 2; k++)
        begin
            v = (k == 0) ? 8'h18 : 8'(8 * $urandom_range(1, 5) + $urandom_range(0, 7));
            bus(1'b1, agptt_pkg::AGPTT_MT_ADDR, v, 4'h1);
            bus(1'b0, agptt_pkg::AGPTT_MT_ADDR, 8'h00, 4'hF);
            check(q, 32'(model_mt));
            ext_go(8'hFF, $urandom_range(0, 3));
            wait_on(3);
            host_rq <= 1'b1;
            count_on(3, n);
            check(n, 32'(model_mt + 1));
            count_on(2, n);
            check(n, 32'(model_mt + 1));
            check(gnt, 32'h8);
            host_rq <= 1'b0;
            ext_go(8'h00, 0);
            repeat (4) @(posedge clock);
            check(gnt, 32'h0);
        end
        // Zero slice: the owner is never timed out
        bus(1'b1, agptt_pkg::AGPTT_MT_ADDR, 8'h07, 4'h1);
        ext_go(8'hFF, 0);
        wait_on(3);
        host_rq <= 1'b1;
        repeat (100) @(posedge clock);
        check(gnt, 32'h8);
        bus(1'b0, agptt_pkg::AGPTT_STAT_ADDR, 8'h00, 4'hF);
        check(q, 32'h00000001);
        host_rq <= 1'b0;
        ext_go(8'h00, 0);
        // Low-priority tenure against a waiting host
        bus(1'b1, agptt_pkg::AGPTT_LP_ADDR, 8'(8 * $urandom_range(1, 4)), 4'hF);
        @(posedge clock);
        lp_rq <= 1'b1;
        lp_wr <= 1'($urandom);
        host_rq <= 1'b1;
        wait_on(1);
        check(lp_write_type, lp_wr);
        count_on(1, n);
        check(n, 32'(model_lp + 1));
        check(gnt, 32'h4);
        host_rq <= 1'b0;
        wait_on(1);
        repeat (model_lp + 8) @(posedge clock);
        check(gnt, 32'h2);
        // A change of transfer type opens a fresh tenure
        lp_wr <= ~lp_wr;
        repeat (2) @(posedge clock);
        check(lp_write_type, lp_wr);
        bus(1'b0, agptt_pkg::AGPTT_STAT_ADDR, 8'h00, 4'hF);
        check(q, 32'((model_lp - 2) * 65536 + 8 * lp_wr + 2));
        bus(1'b1, agptt_pkg::AGPTT_LP_ADDR, 8'h00, 4'hF);
        @(posedge clock);
        hp_rq <= 1'b1;
        repeat (2) @(posedge clock);
        check(gnt, 32'h1);
        hp_rq <= 1'b0;
        wait_on(1);
        lag = $urandom_range(0, 3);
        ext_go(8'hFF, lag);
        n = 0;
        while (gnt.ext !== 1'b1 && n < 12)
        begin
            n++;
            @(posedge clock);
        end
        check(n, 32'(lag + 3));
        lp_rq <= 1'b0;
        ext_go(8'h00, 0);
        print_verdict();
    end
endmodule
